// >>> inc/oms_defines.vh
`ifndef OMS_DEFINES_VH
`define OMS_DEFINES_VH
// mode selection values
`define OMS_SEL_W 3
`define OMS_SEL_SWITCHABLE 3'h0
`define OMS_SEL_PANEL_FIX 3'h1
`define OMS_SEL_EXT_FIX 3'h2
`define OMS_SEL_COMB1 3'h3
`define OMS_SEL_COMB2 3'h4
`define OMS_SEL_SWITCHOVER 3'h6
`define OMS_SEL_INTERLOCK 3'h7
// stop-input logic value that inverts the output-stop input
`define OMS_STOP_LOGIC_W 2
`define OMS_STOP_LOGIC_INV 2'h2
// terminal function codes
`define OMS_FUNC_W 8
`define OMS_FUNC_INTERLOCK 8'h0C
`define OMS_FUNC_PANEL_EXT 8'h10
`define OMS_FUNC_PANEL_REMOTE 8'h41
`define OMS_FUNC_EXT_REMOTE 8'h42
// terminal count (settings 178..182)
`define OMS_NUM_TERM 5
// comm start-up values
`define OMS_COMM_W 4
`define OMS_COMM_NET 4'h1
`define OMS_COMM_PANEL_NET 4'hA
// one-hot mode codes
`define OMS_MODE_W 4
`define OMS_MODE_EXT 4'h1
`define OMS_MODE_PANEL 4'h2
`define OMS_MODE_NET 4'h4
`define OMS_MODE_COMB 4'h8
`endif

// >>> src/oms_sync.v
`timescale 1ns/1ps
`default_nettype none
module oms_sync #(
   parameter WIDTH = 1
) (
   input wire ref_clk_i,
   input wire rst_i,
   input wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);
   reg [WIDTH-1:0] meta_r;
   reg [WIDTH-1:0] sync_r;
   // two-stage synchroniser; first stage only feeds second
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         meta_r <= {WIDTH{1'b0}};
         sync_r <= {WIDTH{1'b0}};
      end else begin
         meta_r <= async_i;
         sync_r <= meta_r;
      end
   end
   assign sync_o = sync_r;
endmodule // oms_sync
`default_nettype wire

// >>> src/oms_mode_selector.v
`timescale 1ns/1ps
`default_nettype none
`include "oms_defines.vh"
module oms_mode_selector #(
   parameter NUM_TERM = `OMS_NUM_TERM
) (
   input wire ref_clk_i,
   input wire rst_i,
   input wire [`OMS_SEL_W-1:0] op_mode_selection_i,
   input wire [`OMS_STOP_LOGIC_W-1:0] stop_input_logic_sel_i,
   input wire [`OMS_COMM_W-1:0] comm_startup_mode_sel_i,
   input wire [NUM_TERM*`OMS_FUNC_W-1:0] input_terminal_function_sel_i,
   input wire [NUM_TERM-1:0] terminal_i,
   input wire output_stop_input_i,
   input wire forward_run_cmd_i,
   input wire reverse_run_cmd_i,
   input wire motor_running_i,
   input wire alarm_i,
   input wire panel_stop_reset_key_i,
   input wire panel_mode_req_i,
   input wire ext_mode_req_i,
   input wire net_mode_req_i,
   input wire param_write_req_i,
   input wire param_write_is_sel_i,
   output wire [`OMS_MODE_W-1:0] op_mode_o,
   output wire output_stop_o,
   output wire param_write_en_o,
   output wire drive_reset_o,
   output wire mode_req_refused_o,
   output wire forced_ext_o
);
   // two-flop synchronisers for the terminal, output-stop, run-command, key and mode-request inputs
   wire [NUM_TERM-1:0] term_s;
   wire stop_in_s;
   wire fwd_s;
   wire rev_s;
   wire key_s;
   wire preq_s;
   wire ereq_s;
   wire nreq_s;

   oms_sync #(.WIDTH(NUM_TERM)) u_sync_term (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .async_i(terminal_i),
      .sync_o(term_s)
   );

   oms_sync #(.WIDTH(1)) u_sync_stop (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .async_i(output_stop_input_i),
      .sync_o(stop_in_s)
   );

   oms_sync #(.WIDTH(1)) u_sync_fwd (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .async_i(forward_run_cmd_i),
      .sync_o(fwd_s)
   );

   oms_sync #(.WIDTH(1)) u_sync_rev (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .async_i(reverse_run_cmd_i),
      .sync_o(rev_s)
   );

   oms_sync #(.WIDTH(1)) u_sync_key (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .async_i(panel_stop_reset_key_i),
      .sync_o(key_s)
   );

   oms_sync #(.WIDTH(1)) u_sync_preq (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .async_i(panel_mode_req_i),
      .sync_o(preq_s)
   );

   oms_sync #(.WIDTH(1)) u_sync_ereq (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .async_i(ext_mode_req_i),
      .sync_o(ereq_s)
   );

   oms_sync #(.WIDTH(1)) u_sync_nreq (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .async_i(net_mode_req_i),
      .sync_o(nreq_s)
   );

   // per-terminal function decode
   wire [NUM_TERM-1:0] is_ilk_w;
   wire [NUM_TERM-1:0] is_pe_w;
   wire [NUM_TERM-1:0] is_pn_w;
   wire [NUM_TERM-1:0] is_en_w;
   genvar g;
   generate
      for (g = 0; g < NUM_TERM; g = g + 1) begin : g_term
         wire [`OMS_FUNC_W-1:0] fn = input_terminal_function_sel_i[g*`OMS_FUNC_W +: `OMS_FUNC_W];
         assign is_ilk_w[g] = (fn == `OMS_FUNC_INTERLOCK);
         assign is_pe_w[g] = (fn == `OMS_FUNC_PANEL_EXT);
         assign is_pn_w[g] = (fn == `OMS_FUNC_PANEL_REMOTE);
         assign is_en_w[g] = (fn == `OMS_FUNC_EXT_REMOTE);
      end
   endgenerate

   wire ilk_assigned = |is_ilk_w;
   wire pe_assigned = |is_pe_w;
   wire pn_assigned = |is_pn_w;
   wire en_assigned = |is_en_w;
   wire sel7 = (op_mode_selection_i == `OMS_SEL_INTERLOCK);
   wire stop_pol = (stop_input_logic_sel_i == `OMS_STOP_LOGIC_INV) ? ~stop_in_s : stop_in_s;
   wire ilk_from_stop = sel7 & ~ilk_assigned;
   wire ilk_on = ilk_assigned ? |(term_s & is_ilk_w) : stop_pol;
   wire ilk_off = sel7 & ~ilk_on;
   wire panel_ext_sw = |(term_s & is_pe_w);
   wire panel_net_sw = |(term_s & is_pn_w);
   wire ext_net_sw = |(term_s & is_en_w);
   wire run_cmd = fwd_s | rev_s;
   wire stopped = ~motor_running_i & ~run_cmd;

   reg [`OMS_MODE_W-1:0] mode_r;
   reg [`OMS_MODE_W-1:0] mode_nxt;
   reg forced_r;
   reg forced_nxt;
   reg refused_r;
   reg refused_nxt;
   reg [`OMS_SEL_W-1:0] sel_last_r;
   reg [`OMS_MODE_W-1:0] init_mode;
   reg [`OMS_MODE_W-1:0] want;
   reg want_valid;
   reg may_switch;

   // mode implied by selection, and for selections 0, 6 and 7 by the comm start-up value
   always @* begin
      init_mode = `OMS_MODE_PANEL;
      case (op_mode_selection_i)
         `OMS_SEL_PANEL_FIX: init_mode = `OMS_MODE_PANEL;
         `OMS_SEL_EXT_FIX: init_mode = `OMS_MODE_EXT;
         `OMS_SEL_COMB1: init_mode = `OMS_MODE_COMB;
         `OMS_SEL_COMB2: init_mode = `OMS_MODE_COMB;
         default: init_mode = (comm_startup_mode_sel_i == `OMS_COMM_NET) ? `OMS_MODE_NET : `OMS_MODE_EXT;
      endcase
   end

   always @* begin
      mode_nxt = mode_r;
      forced_nxt = forced_r;
      refused_nxt = 1'b0;
      want = mode_r;
      want_valid = 1'b0;
      may_switch = stopped;
      if (op_mode_selection_i == `OMS_SEL_SWITCHOVER) begin
         may_switch = 1'b1;
      end
      case (op_mode_selection_i)
         `OMS_SEL_PANEL_FIX: begin
            mode_nxt = `OMS_MODE_PANEL;
            forced_nxt = 1'b0;
         end
         `OMS_SEL_COMB1, `OMS_SEL_COMB2: begin
            mode_nxt = `OMS_MODE_COMB;
            forced_nxt = 1'b0;
         end
         `OMS_SEL_EXT_FIX: begin
            forced_nxt = 1'b0;
            if (en_assigned && stopped) begin
               mode_nxt = ext_net_sw ? `OMS_MODE_NET : `OMS_MODE_EXT;
            end else if (nreq_s && stopped) begin
               mode_nxt = `OMS_MODE_NET;
            end else if (mode_r != `OMS_MODE_NET || ereq_s) begin
               mode_nxt = `OMS_MODE_EXT;
            end
            refused_nxt = preq_s;
         end
         `OMS_SEL_SWITCHABLE, `OMS_SEL_SWITCHOVER, `OMS_SEL_INTERLOCK: begin
            if (ilk_off) begin
               if (mode_r != `OMS_MODE_EXT) begin
                  forced_nxt = 1'b1;
               end
               mode_nxt = `OMS_MODE_EXT;
               refused_nxt = preq_s | nreq_s;
            end else begin
               forced_nxt = 1'b0;
               if (en_assigned && comm_startup_mode_sel_i != `OMS_COMM_PANEL_NET) begin
                  want = ext_net_sw ? `OMS_MODE_NET : (pe_assigned && !panel_ext_sw ? `OMS_MODE_PANEL
                         : `OMS_MODE_EXT);
                  want_valid = 1'b1;
               end else if (pn_assigned && comm_startup_mode_sel_i == `OMS_COMM_PANEL_NET) begin
                  want = panel_net_sw ? (pe_assigned && panel_ext_sw ? `OMS_MODE_EXT : `OMS_MODE_PANEL)
                         : `OMS_MODE_NET;
                  want_valid = 1'b1;
               end else if (pe_assigned) begin
                  want = panel_ext_sw ? `OMS_MODE_EXT : `OMS_MODE_PANEL;
                  want_valid = 1'b1;
               end else if (preq_s) begin
                  want = `OMS_MODE_PANEL;
                  want_valid = 1'b1;
               end else if (ereq_s) begin
                  want = `OMS_MODE_EXT;
                  want_valid = 1'b1;
               end else if (nreq_s) begin
                  want = `OMS_MODE_NET;
                  want_valid = 1'b1;
               end
               if (want_valid && want != mode_r) begin
                  if (!may_switch) begin
                     refused_nxt = 1'b1;
                  end else if (want == `OMS_MODE_PANEL && run_cmd) begin
                     refused_nxt = 1'b1;
                  end else begin
                     mode_nxt = want;
                  end
               end
            end
         end
         default: begin
            mode_nxt = init_mode;
            forced_nxt = 1'b0;
         end
      endcase
      if (mode_r == `OMS_MODE_COMB && mode_nxt != `OMS_MODE_COMB && op_mode_selection_i != `OMS_SEL_COMB1 &&
          op_mode_selection_i != `OMS_SEL_COMB2 && op_mode_selection_i != sel_last_r) begin
         mode_nxt = init_mode;
      end
   end

   // mode register; a selection change reloads its implied mode, except a change to 7 while the interlock is off
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         mode_r <= init_mode;
         forced_r <= 1'b0;
         refused_r <= 1'b0;
         sel_last_r <= `OMS_SEL_SWITCHABLE;
      end else if (sel_last_r != op_mode_selection_i && !(sel7 && ilk_off)) begin
         mode_r <= init_mode;
         forced_r <= 1'b0;
         refused_r <= 1'b0;
         sel_last_r <= op_mode_selection_i;
      end else begin
         mode_r <= mode_nxt;
         forced_r <= forced_nxt;
         refused_r <= refused_nxt;
         sel_last_r <= op_mode_selection_i;
      end
   end

   // registered outputs
   reg stop_r;
   reg reset_r;
   reg wen_r;
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         stop_r <= 1'b0;
         reset_r <= 1'b0;
         wen_r <= 1'b0;
      end else begin
         if (ilk_from_stop) begin
            stop_r <= ilk_on && mode_r == `OMS_MODE_EXT && motor_running_i;
         end else begin
            stop_r <= stop_pol;
         end
         reset_r <= forced_r & alarm_i & key_s;
         wen_r <= param_write_req_i & (~ilk_off | param_write_is_sel_i);
      end
   end

   assign op_mode_o = mode_r;
   assign output_stop_o = stop_r;
   assign drive_reset_o = reset_r;
   assign param_write_en_o = wen_r;
   assign mode_req_refused_o = refused_r;
   assign forced_ext_o = forced_r;
endmodule // oms_mode_selector
`default_nettype wire

// >>> test/oms_term_model.sv
`timescale 1ns/1ps
`default_nettype none
module oms_term_model (
   input wire logic ref_clk_i,
   input wire logic [11:0] cmd_i,
   output logic [4:0] terminal_o,
   output logic output_stop_o,
   output logic fwd_o,
   output logic rev_o,
   output logic key_o,
   output logic [2:0] req_o
);
   // contacts and keys change just after the edge and hold their level
   initial {req_o, key_o, rev_o, fwd_o, output_stop_o, terminal_o} = 12'h000;
   always @(posedge ref_clk_i) begin
      {req_o, key_o, rev_o, fwd_o, output_stop_o, terminal_o} <= cmd_i;
   end
endmodule // oms_term_model
`default_nettype wire

// >>> test/oms_mode_selector_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "oms_defines.vh"
module oms_mode_checker #(
   parameter NUM_TERM = `OMS_NUM_TERM
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [`OMS_SEL_W-1:0] op_mode_selection_i,
   input wire logic [`OMS_STOP_LOGIC_W-1:0] stop_input_logic_sel_i,
   input wire logic [NUM_TERM*`OMS_FUNC_W-1:0] input_terminal_function_sel_i,
   input wire logic output_stop_input_i,
   input wire logic motor_running_i,
   input wire logic alarm_i,
   input wire logic param_write_req_i,
   input wire logic param_write_is_sel_i,
   input wire logic [`OMS_MODE_W-1:0] op_mode_o,
   input wire logic output_stop_o,
   input wire logic param_write_en_o,
   input wire logic drive_reset_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   logic il_term;
   always_comb begin
      il_term = 1'b0;
      for (int k = 0; k < NUM_TERM; k++) begin
         il_term = il_term | (input_terminal_function_sel_i[k*`OMS_FUNC_W +: `OMS_FUNC_W] == `OMS_FUNC_INTERLOCK);
      end
   end
   // interlock taken from the output-stop input, after polarity
   wire il_off = (op_mode_selection_i == `OMS_SEL_INTERLOCK) && !il_term &&
      !(output_stop_input_i ^ (stop_input_logic_sel_i == `OMS_STOP_LOGIC_INV));
   sequence s_sel(logic [2:0] v);
      (op_mode_selection_i == v) [*3];
   endsequence
   sequence s_il_off;
      il_off [*4];
   endsequence
   sequence s_run0;
      (op_mode_selection_i == 3'h0 && motor_running_i) [*6];
   endsequence
   AST_ONEHOT: assert property (op_mode_o inside {4'h1, 4'h2, 4'h4, 4'h8}) else $error("mode not one-hot");
   AST_SEL1: assert property (s_sel(3'h1) |-> op_mode_o == `OMS_MODE_PANEL) else $error("sel 1 not panel");
   AST_SEL2: assert property (s_sel(3'h2) |-> op_mode_o != `OMS_MODE_PANEL) else $error("sel 2 in panel");
   AST_SEL3: assert property (s_sel(3'h3) |-> op_mode_o == `OMS_MODE_COMB) else $error("sel 3 not comb");
   AST_SEL4: assert property (s_sel(3'h4) |-> op_mode_o == `OMS_MODE_COMB) else $error("sel 4 not comb");
   AST_WR_LATE: assert property (param_write_en_o |-> $past(param_write_req_i)) else $error("write without request");
   AST_WR_BLOCK: assert property (s_il_off ##0 (param_write_req_i && !param_write_is_sel_i)
      |=> !param_write_en_o) else $error("write not blocked");
   AST_IL_EXT: assert property (s_il_off |-> op_mode_o == `OMS_MODE_EXT) else $error("interlock off not ext");
   AST_ALARM_RST: assert property ($rose(drive_reset_o) |-> $past(alarm_i)) else $error("reset without alarm");
   AST_STOP_EXT: assert property ((output_stop_o && $past(op_mode_selection_i) == 3'h7 && !$past(il_term))
      |-> ($past(motor_running_i) && $past(op_mode_o) == `OMS_MODE_EXT)) else $error("stop outside ext run");
   AST_RUN_HOLD: assert property (s_run0 |=> $stable(op_mode_o)) else $error("mode changed while running");
endmodule // oms_mode_checker
bind oms_mode_selector oms_mode_checker #(.NUM_TERM(NUM_TERM)) u_chk (.ref_clk_i, .rst_i, .op_mode_selection_i,
   .stop_input_logic_sel_i, .input_terminal_function_sel_i, .output_stop_input_i, .motor_running_i, .alarm_i,
   .param_write_req_i, .param_write_is_sel_i, .op_mode_o, .output_stop_o, .param_write_en_o, .drive_reset_o);
`default_nettype wire

// >>> test/oms_mode_selector_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "oms_defines.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module oms_mode_selector_tb;
   localparam logic [11:0] PE_SW = 12'h001, STOP = 12'h020, FWD = 12'h040, KEY = 12'h100, PREQ = 12'h200, NREQ = 12'h800;
   logic ref_clk = 0, rst = 1, motor = 0, alarm = 0, pw_req = 0, pw_sel = 0;
   logic [2:0] sel = 3'h0;
   logic [1:0] slog = 2'h0;
   logic [3:0] comm = 4'h0;
   logic [39:0] func = 40'h10;
   logic [11:0] cmd = 12'h000;
   wire [4:0] term;
   wire [2:0] req;
   wire [3:0] mode;
   wire stop_in, fwd, rev, key, ostop, pw_en, drst, refused, forced;
   int error_cnt = 0, n_checks = 0;
   oms_term_model u_model (.ref_clk_i(ref_clk), .cmd_i(cmd), .terminal_o(term), .output_stop_o(stop_in),
      .fwd_o(fwd), .rev_o(rev), .key_o(key), .req_o(req));
   oms_mode_selector dut (.ref_clk_i(ref_clk), .rst_i(rst), .op_mode_selection_i(sel), .stop_input_logic_sel_i(slog),
      .comm_startup_mode_sel_i(comm), .input_terminal_function_sel_i(func), .terminal_i(term),
      .output_stop_input_i(stop_in), .forward_run_cmd_i(fwd), .reverse_run_cmd_i(rev), .motor_running_i(motor),
      .alarm_i(alarm), .panel_stop_reset_key_i(key), .panel_mode_req_i(req[0]), .ext_mode_req_i(req[1]),
      .net_mode_req_i(req[2]), .param_write_req_i(pw_req), .param_write_is_sel_i(pw_sel), .op_mode_o(mode),
      .output_stop_o(ostop), .param_write_en_o(pw_en), .drive_reset_o(drst), .mode_req_refused_o(refused),
      .forced_ext_o(forced));
   initial forever #2.5 ref_clk = ~ref_clk;
   task cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task put(input logic [2:0] s, input logic [11:0] c, input logic m);
      @(posedge ref_clk);
      sel <= s;
      cmd <= c;
      motor <= m;
      cyc(6);
   endtask
   task catch_hi(input bit w);
      bit seen;
      seen = 0;
      repeat (8) begin
         @(posedge ref_clk);
         #1;
         if ((w ? drst : refused) === 1'b1) seen = 1;
      end
      `CHK(seen, 1'b1)
   endtask
   task t_fixed;
      logic [2:0] s [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
      logic [3:0] e [4] = '{`OMS_MODE_PANEL, `OMS_MODE_EXT, `OMS_MODE_COMB, `OMS_MODE_COMB};
      for (int i = 0; i < 8; i++) begin
         put(s[i/2], 12'(i % 2), 0);
         `CHK(mode, e[i/2])
      end
      put(3'h2, NREQ, 0);
      `CHK(mode, `OMS_MODE_NET)
      $display("t_fixed done");
   endtask
   task t_switch;
      put(3'h0, PE_SW, 0);
      `CHK(mode, `OMS_MODE_EXT)
      put(3'h0, 12'h000, 0);
      `CHK(mode, `OMS_MODE_PANEL)
      @(posedge ref_clk);
      func <= 40'h0;
      put(3'h0, PE_SW, 0);
      `CHK(mode, `OMS_MODE_PANEL)
      @(posedge ref_clk);
      func <= 40'h10;
      put(3'h0, 12'h000, 1);
      `CHK(mode, `OMS_MODE_EXT)
      put(3'h6, PE_SW, 1);
      put(3'h6, 12'h000, 1);
      `CHK(mode, `OMS_MODE_PANEL)
      put(3'h6, PE_SW | FWD, 1);
      `CHK(mode, `OMS_MODE_EXT)
      put(3'h6, FWD, 1);
      `CHK(mode, `OMS_MODE_EXT)
      `CHK(refused, 1'b1)
      put(3'h0, 12'h000, 0);
      $display("t_switch done");
   endtask
   task t_priority;
      @(posedge ref_clk);
      func <= 40'h4210;
      put(3'h0, PE_SW | 12'h002, 0);
      `CHK(mode, `OMS_MODE_NET)
      put(3'h0, PE_SW, 0);
      `CHK(mode, `OMS_MODE_EXT)
      @(posedge ref_clk);
      func <= 40'h41;
      comm <= 4'hA;
      put(3'h0, PE_SW, 0);
      `CHK(mode, `OMS_MODE_PANEL)
      put(3'h0, 12'h000, 0);
      `CHK(mode, `OMS_MODE_NET)
      @(posedge ref_clk);
      func <= 40'h0;
      comm <= 4'h1;
      put(3'h1, 12'h000, 0);
      put(3'h0, 12'h000, 0);
      `CHK(mode, `OMS_MODE_NET)
      @(posedge ref_clk);
      rst <= 1;
      cyc(2);
      `CHK(mode, `OMS_MODE_NET)
      @(posedge ref_clk);
      rst <= 0;
      cyc(3);
      `CHK(mode, `OMS_MODE_NET)
      @(posedge ref_clk);
      func <= 40'h10;
      comm <= 4'h0;
      $display("t_priority done");
   endtask
   task t_interlock;
      put(3'h7, STOP, 0);
      `CHK(mode, `OMS_MODE_PANEL)
      put(3'h7, 12'h000, 0);
      `CHK(mode, `OMS_MODE_EXT)
      `CHK(forced, 1'b1)
      @(posedge ref_clk);
      cmd <= PREQ;
      catch_hi(0);
      `CHK(mode, `OMS_MODE_EXT)
      @(posedge ref_clk);
      pw_req <= 1;
      cyc(3);
      `CHK(pw_en, 1'b0)
      @(posedge ref_clk);
      pw_sel <= 1;
      cyc(2);
      `CHK(pw_en, 1'b1)
      @(posedge ref_clk);
      pw_req <= 0;
      alarm <= 1;
      cmd <= KEY;
      catch_hi(1);
      @(posedge ref_clk);
      alarm <= 0;
      put(3'h7, STOP | FWD, 1);
      `CHK(ostop, 1'b1)
      put(3'h7, FWD, 1);
      `CHK(ostop, 1'b0)
      @(posedge ref_clk);
      slog <= 2'h2;
      cyc(6);
      `CHK(ostop, 1'b1)
      @(posedge ref_clk);
      slog <= 2'h0;
      put(3'h7, STOP | FWD, 0);
      @(posedge ref_clk);
      cmd <= STOP | FWD | PREQ;
      catch_hi(0);
      `CHK(mode, `OMS_MODE_EXT)
      put(3'h0, 12'h000, 0);
      `CHK(forced, 1'b0)
      put(3'h0, STOP, 0);
      `CHK(ostop, 1'b1)
      $display("t_interlock done");
   endtask
   task end_of_test;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 0;
      t_fixed;
      t_switch;
      t_priority;
      t_interlock;
      end_of_test;
   end
   initial begin
      #100000;
      error_cnt++;
      end_of_test;
   end
endmodule // oms_mode_selector_tb
`default_nettype wire
